//--- rtl/obcd_pkg.sv
// package for the option byte configuration decoder
package obcd_pkg;
	localparam logic [7:0] CFG0_ERASED   = 8'hFF;
	localparam logic [7:0] CFG1_ERASED   = 8'hFF;
	localparam logic [7:0] CFG0_DEFAULT  = 8'hFE;
	localparam logic [7:0] CFG1_DEFAULT  = 8'hEF;
	localparam logic [7:0] CFG0_RSVD_MSK = 8'hFC;
	localparam int IRQ_MAP_BIT   = 1;
	localparam int PROTECT_BIT   = 0;
	localparam int FILTER_BIT    = 7;
	localparam int OSC_LSB       = 4;
	localparam int LVD_LSB       = 2;
	localparam int HALT_WDG_BIT  = 1;
	localparam int WDG_SOFT_BIT  = 0;
	localparam logic [11:0] ADDR_CTRL   = 12'h000;
	localparam logic [11:0] ADDR_STATUS = 12'h004;
	localparam logic [11:0] ADDR_DEC    = 12'h008;
	localparam logic [1:0] RESP_OKAY   = 2'h0;
	localparam logic [1:0] RESP_SLVERR = 2'h2;
	localparam int ERASE_WORDS = 4096;

	typedef enum logic [2:0] {
		OBCD_OSC_HS   = 3'h0,
		OBCD_OSC_MS   = 3'h1,
		OBCD_OSC_MP   = 3'h2,
		OBCD_OSC_LP   = 3'h3,
		OBCD_OSC_XRC  = 3'h4,
		OBCD_OSC_IRC  = 3'h6,
		OBCD_OSC_XCLK = 3'h7
	} obcd_osc_type;

	typedef enum logic [1:0] {
		OBCD_LVD_LOW  = 2'h0,
		OBCD_LVD_MED  = 2'h1,
		OBCD_LVD_HIGH = 2'h2,
		OBCD_LVD_OFF  = 2'h3
	} obcd_lvd_type;

	typedef enum logic [1:0] {
		OBCD_IDLE  = 2'h0,
		OBCD_ERASE = 2'h1
	} obcd_state_type;

	typedef struct packed {
		logic       vec_first_port_a;
		logic       vec_first_port_c;
		logic       vec_second_port_b;
		logic       vec_second_port_c;
		logic       readout_protect;
		logic       clock_filter_en;
		logic [2:0] oscillator_select;
		logic       lvd_enable;
		logic [1:0] low_voltage_level;
		logic       halt_watchdog_reset;
		logic       watchdog_hw_always_on;
	} obcd_settings_type;

	typedef struct packed {
		obcd_state_type    state;
		logic [7:0]        cfg0;
		logic [7:0]        cfg1;
		logic [11:0]       erase_addr;
		logic              erase_done;
		logic              in_reset;
		obcd_settings_type settings;
		logic              awdone;
		logic              wdone;
		logic [11:0]       waddr;
		logic [31:0]       wdata;
		logic              bvalid;
		logic [1:0]        bresp;
		logic              rvalid;
		logic [31:0]       rdata;
		logic [1:0]        rresp;
	} obcd_state_all_type;
endpackage

//--- rtl/obcd_option_decoder.sv
// option byte decoder with programming port and axi4-lite status view
//
// The placing of the registers and register access over AXI4-Lite are this design's own decisions.
`timescale 1ns/1ps
`default_nettype none
module obcd_option_decoder #(
	parameter bit         FACTORY_CODED = 1'b0,
	parameter logic [7:0] MASK_CFG0     = obcd_pkg::CFG0_DEFAULT,
	parameter logic [7:0] MASK_CFG1     = obcd_pkg::CFG1_DEFAULT,
	parameter int         ERASE_WORDS   = obcd_pkg::ERASE_WORDS
) (
	input  wire logic                        aclk,
	input  wire logic                        aresetn,
	input  wire logic                        prog_mode,
	input  wire logic                        prog_wr,
	input  wire logic                        prog_sel,
	input  wire logic [7:0]                  prog_wdata,
	output logic      [7:0]                  prog_rdata,
	input  wire logic                        halt_entry,
	input  wire logic                        watchdog_active,
	output logic                             halt_reset_req,
	output logic                             erase_wr,
	output logic      [11:0]                 erase_addr,
	output obcd_pkg::obcd_settings_type      settings,
	input  wire logic [11:0]                 s_axi_awaddr,
	input  wire logic                        s_axi_awvalid,
	output logic                             s_axi_awready,
	input  wire logic [31:0]                 s_axi_wdata,
	input  wire logic [3:0]                  s_axi_wstrb,
	input  wire logic                        s_axi_wvalid,
	output logic                             s_axi_wready,
	output logic      [1:0]                  s_axi_bresp,
	output logic                             s_axi_bvalid,
	input  wire logic                        s_axi_bready,
	input  wire logic [11:0]                 s_axi_araddr,
	input  wire logic                        s_axi_arvalid,
	output logic                             s_axi_arready,
	output logic      [31:0]                 s_axi_rdata,
	output logic      [1:0]                  s_axi_rresp,
	output logic                             s_axi_rvalid,
	input  wire logic                        s_axi_rready
);
	// option storage survives reset; power-up content is the erased value
	obcd_pkg::obcd_state_all_type st_ff = '{
		state:   obcd_pkg::OBCD_IDLE,
		cfg0:    obcd_pkg::CFG0_ERASED,
		cfg1:    obcd_pkg::CFG1_ERASED,
		default: '0
	};
	obcd_pkg::obcd_state_all_type nxt_st;
	logic [7:0] eff0;
	logic [7:0] eff1;

	function automatic obcd_pkg::obcd_settings_type decode(input logic [7:0] b0,
		input logic [7:0] b1);
		obcd_pkg::obcd_settings_type s;
		s.vec_first_port_a      = 1'b1;
		s.vec_second_port_b     = 1'b1;
		s.vec_first_port_c      = ~b0[obcd_pkg::IRQ_MAP_BIT];
		s.vec_second_port_c     = b0[obcd_pkg::IRQ_MAP_BIT];
		s.readout_protect       = b0[obcd_pkg::PROTECT_BIT];
		s.clock_filter_en       = ~b1[obcd_pkg::FILTER_BIT];
		s.oscillator_select     = b1[obcd_pkg::OSC_LSB +: 3];
		if (b1[obcd_pkg::OSC_LSB + 2 -: 2] == 2'h2) begin
			s.oscillator_select = obcd_pkg::OBCD_OSC_XRC;
		end
		s.low_voltage_level     = b1[obcd_pkg::LVD_LSB +: 2];
		s.lvd_enable            = (b1[obcd_pkg::LVD_LSB +: 2] != obcd_pkg::OBCD_LVD_OFF);
		s.halt_watchdog_reset   = b1[obcd_pkg::HALT_WDG_BIT];
		s.watchdog_hw_always_on = ~b1[obcd_pkg::WDG_SOFT_BIT];
		return s;
	endfunction

	// factory parts ignore stored bits entirely
	assign eff0 = FACTORY_CODED ? MASK_CFG0 : st_ff.cfg0;
	assign eff1 = FACTORY_CODED ? MASK_CFG1 : st_ff.cfg1;

	always_comb begin
		nxt_st = st_ff;
		nxt_st.in_reset = 1'b0;
		// programming port only, no bus address reaches the bytes
		if (prog_mode && prog_wr && !FACTORY_CODED) begin
			if (!prog_sel) begin
				nxt_st.cfg0 = prog_wdata;
				if (st_ff.cfg0[obcd_pkg::PROTECT_BIT] && !prog_wdata[obcd_pkg::PROTECT_BIT]) begin
					nxt_st.state = obcd_pkg::OBCD_ERASE;
					nxt_st.erase_addr = 12'h000;
					nxt_st.erase_done = 1'b0;
				end
			end else begin
				nxt_st.cfg1 = prog_wdata;
			end
		end
		case (st_ff.state)
			obcd_pkg::OBCD_IDLE: begin
			end
			obcd_pkg::OBCD_ERASE: begin
				if (st_ff.erase_addr == 12'(ERASE_WORDS - 1)) begin
					nxt_st.state = obcd_pkg::OBCD_IDLE;
					nxt_st.erase_done = 1'b1;
				end else begin
					nxt_st.erase_addr = st_ff.erase_addr + 12'h001;
				end
			end
			default: nxt_st.state = obcd_pkg::OBCD_IDLE;
		endcase
		// axi write: accept address and data in either order
		if (s_axi_awvalid && !st_ff.awdone && !st_ff.bvalid) begin
			nxt_st.awdone = 1'b1;
			nxt_st.waddr = s_axi_awaddr;
		end
		if (s_axi_wvalid && !st_ff.wdone && !st_ff.bvalid) begin
			nxt_st.wdone = 1'b1;
			nxt_st.wdata = s_axi_wdata;
		end
		if (st_ff.awdone && st_ff.wdone && !st_ff.bvalid) begin
			nxt_st.bvalid = 1'b1;
			nxt_st.awdone = 1'b0;
			nxt_st.wdone = 1'b0;
			nxt_st.bresp = obcd_pkg::RESP_SLVERR;
			// only the control word is writable; it restarts nothing
			if (st_ff.waddr == obcd_pkg::ADDR_CTRL) begin
				nxt_st.bresp = obcd_pkg::RESP_OKAY;
				if (s_axi_wstrb[0] && st_ff.wdata[0]) begin
					nxt_st.erase_done = 1'b0;
				end
			end
		end
		if (st_ff.bvalid && s_axi_bready) begin
			nxt_st.bvalid = 1'b0;
		end
		if (s_axi_arvalid && !st_ff.rvalid) begin
			nxt_st.rvalid = 1'b1;
			nxt_st.rresp = obcd_pkg::RESP_OKAY;
			case (s_axi_araddr)
				obcd_pkg::ADDR_CTRL: nxt_st.rdata = 32'h0000_0000;
				obcd_pkg::ADDR_STATUS: nxt_st.rdata = {29'h0000_0000,
					st_ff.erase_done, st_ff.state == obcd_pkg::OBCD_ERASE, prog_mode};
				obcd_pkg::ADDR_DEC: nxt_st.rdata = {18'h0_0000, st_ff.settings};
				default: begin
					nxt_st.rdata = 32'h0000_0000;
					nxt_st.rresp = obcd_pkg::RESP_SLVERR;
				end
			endcase
		end
		if (st_ff.rvalid && s_axi_rready) begin
			nxt_st.rvalid = 1'b0;
		end
		// fresh settings only latched while reset is asserted, except readout_protect, which clears once an erase is done
		nxt_st.settings = st_ff.settings;
		if (st_ff.erase_done && !st_ff.cfg0[obcd_pkg::PROTECT_BIT]) begin
			// a set protection bit can only block, never be read back early
			nxt_st.settings.readout_protect = 1'b0;
		end
		if (!aresetn) begin
			nxt_st = st_ff;
			nxt_st.in_reset = 1'b1;
			nxt_st.state = obcd_pkg::OBCD_IDLE;
			nxt_st.awdone = 1'b0;
			nxt_st.wdone = 1'b0;
			nxt_st.bvalid = 1'b0;
			nxt_st.rvalid = 1'b0;
			nxt_st.settings = decode(eff0, eff1);
		end
	end

	always_ff @(posedge aclk) begin
		st_ff <= nxt_st;
	end

	assign prog_rdata = !prog_mode ? 8'h00 : (prog_sel ? eff1 : eff0);
	assign halt_reset_req = halt_entry && watchdog_active && st_ff.settings.halt_watchdog_reset;
	assign erase_wr = (st_ff.state == obcd_pkg::OBCD_ERASE);
	assign erase_addr = st_ff.erase_addr;
	assign settings = st_ff.settings;
	assign s_axi_awready = !st_ff.awdone && !st_ff.bvalid;
	assign s_axi_wready = !st_ff.wdone && !st_ff.bvalid;
	assign s_axi_bvalid = st_ff.bvalid;
	assign s_axi_bresp = st_ff.bresp;
	assign s_axi_arready = !st_ff.rvalid;
	assign s_axi_rvalid = st_ff.rvalid;
	assign s_axi_rdata = st_ff.rdata;
	assign s_axi_rresp = st_ff.rresp;

	property p_no_prog_outside_mode;
		@(posedge aclk) disable iff (!aresetn)
		!prog_mode |-> prog_rdata == 8'h00;
	endproperty
	a_no_prog_outside_mode: assert property (p_no_prog_outside_mode)
		else $error("option byte visible outside programming mode");

	property p_irq_map;
		@(posedge aclk) disable iff (!aresetn)
		settings.vec_first_port_c != settings.vec_second_port_c;
	endproperty
	a_irq_map: assert property (p_irq_map)
		else $error("port C mapped to both or no vector");

	property p_erase_start;
		@(posedge aclk) disable iff (!aresetn)
		(prog_mode && prog_wr && !prog_sel && !FACTORY_CODED
			&& st_ff.cfg0[0] && !prog_wdata[0]) |=> erase_wr && erase_addr == 12'h000;
	endproperty
	a_erase_start: assert property (p_erase_start)
		else $error("erase did not start on protection clear");

	property p_erase_walk;
		@(posedge aclk) disable iff (!aresetn)
		(erase_wr && erase_addr != 12'(ERASE_WORDS - 1)) |=> erase_addr == $past(erase_addr) + 12'h001;
	endproperty
	a_erase_walk: assert property (p_erase_walk)
		else $error("erase address skipped");

	property p_lvd_off;
		@(posedge aclk) disable iff (!aresetn)
		settings.lvd_enable == (settings.low_voltage_level != 2'h3);
	endproperty
	a_lvd_off: assert property (p_lvd_off)
		else $error("low voltage enable disagrees with level");

	property p_halt_reset;
		@(posedge aclk) disable iff (!aresetn)
		(halt_entry && watchdog_active) |-> halt_reset_req == settings.halt_watchdog_reset;
	endproperty
	a_halt_reset: assert property (p_halt_reset)
		else $error("halt reset request wrong");

	property p_osc_legal;
		@(posedge aclk) disable iff (!aresetn)
		settings.oscillator_select != 3'h5;
	endproperty
	a_osc_legal: assert property (p_osc_legal)
		else $error("external rc not folded to one code");

	property p_hold;
		@(posedge aclk) disable iff (!aresetn)
		$past(aresetn) && !erase_wr |=> $stable(settings.oscillator_select)
			&& $stable(settings.watchdog_hw_always_on) && $stable(settings.clock_filter_en);
	endproperty
	a_hold: assert property (p_hold)
		else $error("settings changed outside reset");

	property p_wresp;
		@(posedge aclk) disable iff (!aresetn)
		(s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready) |=> ##1 s_axi_bvalid;
	endproperty
	a_wresp: assert property (p_wresp)
		else $error("write response late");

	property p_bhold;
		@(posedge aclk) disable iff (!aresetn)
		s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && $stable(s_axi_bresp);
	endproperty
	a_bhold: assert property (p_bhold)
		else $error("write response dropped before taken");

	property p_rhold;
		@(posedge aclk) disable iff (!aresetn)
		s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata);
	endproperty
	a_rhold: assert property (p_rhold)
		else $error("read data dropped before taken");

	property p_prog_write;
		@(posedge aclk) disable iff (!aresetn)
		(prog_mode && prog_wr && !prog_sel && !FACTORY_CODED) |=> st_ff.cfg0 == $past(prog_wdata);
	endproperty
	a_prog_write: assert property (p_prog_write)
		else $error("programming write to byte zero lost");

	property p_no_write_outside;
		@(posedge aclk) disable iff (!aresetn)
		!prog_mode |=> st_ff.cfg0 == $past(st_ff.cfg0) && st_ff.cfg1 == $past(st_ff.cfg1);
	endproperty
	a_no_write_outside: assert property (p_no_write_outside)
		else $error("option byte changed outside programming mode");

	property p_prog_read;
		@(posedge aclk) disable iff (!aresetn)
		prog_mode |-> prog_rdata == (prog_sel ? eff1 : eff0);
	endproperty
	a_prog_read: assert property (p_prog_read)
		else $error("programming read shows wrong byte");

	property p_factory;
		@(posedge aclk) disable iff (!aresetn)
		(FACTORY_CODED == 1'b1) |-> eff0 == MASK_CFG0 && eff1 == MASK_CFG1;
	endproperty
	a_factory: assert property (p_factory)
		else $error("factory part not using fixed option values");

	property p_erase_end;
		@(posedge aclk) disable iff (!aresetn)
		erase_wr && erase_addr == 12'(ERASE_WORDS - 1) |=> !erase_wr;
	endproperty
	a_erase_end: assert property (p_erase_end)
		else $error("erase ran past last word");

	property p_load_map;
		@(posedge aclk)
		!aresetn |=> settings.vec_second_port_c == $past(eff0[obcd_pkg::IRQ_MAP_BIT]);
	endproperty
	a_load_map: assert property (p_load_map)
		else $error("interrupt map not loaded in reset");

	property p_load_protect;
		@(posedge aclk)
		!aresetn |=> settings.readout_protect == $past(eff0[obcd_pkg::PROTECT_BIT]);
	endproperty
	a_load_protect: assert property (p_load_protect)
		else $error("protection not loaded in reset");

	property p_load_filter;
		@(posedge aclk)
		!aresetn |=> settings.clock_filter_en == !$past(eff1[obcd_pkg::FILTER_BIT]);
	endproperty
	a_load_filter: assert property (p_load_filter)
		else $error("clock filter not loaded in reset");

	property p_load_osc;
		@(posedge aclk)
		!aresetn && eff1[6:5] != 2'h2 |=> settings.oscillator_select == $past(eff1[6:4]);
	endproperty
	a_load_osc: assert property (p_load_osc)
		else $error("oscillator select not loaded in reset");

	property p_load_lvd;
		@(posedge aclk)
		!aresetn |=> settings.low_voltage_level == $past(eff1[3:2]);
	endproperty
	a_load_lvd: assert property (p_load_lvd)
		else $error("low voltage level not loaded in reset");

	property p_load_wdg;
		@(posedge aclk)
		!aresetn |=> settings.watchdog_hw_always_on == !$past(eff1[obcd_pkg::WDG_SOFT_BIT]);
	endproperty
	a_load_wdg: assert property (p_load_wdg)
		else $error("watchdog type not loaded in reset");
endmodule // obcd_option_decoder
`default_nettype wire

//--- verif/obcd_prog_tool.sv
// programming tool model driving the option byte port
`timescale 1ns/1ps
`default_nettype none
module obcd_prog_tool (
	input  wire logic       aclk,
	output logic            prog_mode,
	output logic            prog_wr,
	output logic            prog_sel,
	output logic      [7:0] prog_wdata
);
	initial begin
		prog_mode  = 1'b0;
		prog_wr    = 1'b0;
		prog_sel   = 1'b0;
		prog_wdata = 8'hA5;
	end
	task automatic set_mode(input logic m);
		@(posedge aclk);
		prog_mode <= m;
	endtask
	task automatic write_byte(input logic sel, input logic [7:0] val, input int gap);
		repeat (gap) @(posedge aclk);
		prog_wr    <= 1'b1;
		prog_sel   <= sel;
		prog_wdata <= sel ? val : (val | obcd_pkg::CFG0_RSVD_MSK);
		@(posedge aclk);
		prog_wr    <= 1'b0;
		prog_wdata <= ~prog_wdata;
	endtask
endmodule // obcd_prog_tool
`default_nettype wire

//--- verif/tb.sv
// self-checking bench for the option byte decoder
`timescale 1ns/1ps
`default_nettype none
`define CHK(nm, e, a) begin \
	n_compared++; \
	if ((a) !== (e)) begin \
		errors++; \
		$display("CHECK FAILED %s exp %h got %h", nm, e, a); \
	end \
end
`define TMO begin errors++; print_verdict(); end
`define WAITHI(s) begin \
	@(negedge aclk); \
	for (k = 0; k < 50 && (s) !== 1'b1; k++) @(negedge aclk); \
	if (k >= 50) `TMO \
	@(posedge aclk); \
end
module tb;
	typedef struct {int kind; logic [33:0] exp;} obcd_note_type;
	logic        aclk, aresetn, halt_entry, watchdog_active, halt_reset_req, erase_wr, look;
	logic        prog_mode, prog_wr, prog_sel;
	logic [7:0]  prog_wdata, prog_rdata, b0, b1;
	logic [11:0] erase_addr, s_axi_awaddr, s_axi_araddr;
	logic [31:0] s_axi_wdata, s_axi_rdata;
	logic [1:0]  s_axi_bresp, s_axi_rresp, h;
	logic        s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready;
	logic        s_axi_bvalid, s_axi_bready, s_axi_arvalid, s_axi_arready;
	logic        s_axi_rvalid, s_axi_rready;
	logic [3:0]  s_axi_wstrb;
	logic [33:0] act;
	logic [13:0] prev;
	obcd_pkg::obcd_settings_type settings;
	obcd_note_type notes[$];
	obcd_note_type nt;
	int          errors, n_compared, seed, ecnt, k, i;
	string       kn[6] = '{"settings", "prog_rdata", "halt_reset_req", "rdata", "resp", "erase"};

	initial begin
		aclk = 1'b0;
		forever #20 aclk = ~aclk;
	end

	obcd_option_decoder #(.ERASE_WORDS(16)) i_dut (
		.aclk, .aresetn, .prog_mode, .prog_wr, .prog_sel, .prog_wdata, .prog_rdata,
		.halt_entry, .watchdog_active, .halt_reset_req, .erase_wr, .erase_addr, .settings,
		.s_axi_awaddr, .s_axi_awvalid, .s_axi_awready, .s_axi_wdata, .s_axi_wstrb,
		.s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready,
		.s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp,
		.s_axi_rvalid, .s_axi_rready
	);
	obcd_prog_tool i_tool (.aclk, .prog_mode, .prog_wr, .prog_sel, .prog_wdata);

	function automatic logic [13:0] exp_set(input logic [7:0] c0, input logic [7:0] c1);
		return {1'b1, ~c0[1], 1'b1, c0[1], c0[0], ~c1[7],
			(c1[6:5] == 2'h2) ? 3'h4 : c1[6:4], c1[3:2] != 2'h3, c1[3:2],
			c1[1], ~c1[0]};
	endfunction

	task automatic print_verdict();
		$display("compared %0d mismatches %0d", n_compared, errors);
		if (errors == 0 && n_compared > 0)
			$display("ALL CHECKS OK");
		else
			$display("CHECKS NOT OK");
		$finish;
	endtask

	// sampled kinds raise look for one cycle and let an edge pass after
	task automatic note(input int kind, input logic [33:0] e);
		notes.push_back('{kind, e});
		if (kind < 3) begin
			look <= 1'b1;
			@(posedge aclk);
			look <= 1'b0;
			@(posedge aclk);
		end
	endtask

	task automatic drain();
		for (k = 0; k < 200 && notes.size() > 0; k++) @(posedge aclk);
		if (k >= 200) `TMO
	endtask

	task automatic do_reset();
		aresetn <= 1'b0;
		repeat (6) @(posedge aclk);
		aresetn <= 1'b1;
		@(posedge aclk);
	endtask

	task automatic axi_rd(input logic [11:0] a, input int kind, input logic [33:0] e);
		note(kind, e);
		s_axi_araddr  <= a;
		s_axi_arvalid <= 1'b1;
		s_axi_rready  <= 1'b1;
		`WAITHI(s_axi_arready)
		s_axi_arvalid <= 1'b0;
		`WAITHI(s_axi_rvalid)
		s_axi_rready <= 1'b0;
	endtask

	task automatic axi_wr(input logic [11:0] a, input logic [31:0] d, input logic [1:0] r);
		logic aw;
		logic w;
		note(4, {32'h0, r});
		s_axi_awaddr  <= a;
		s_axi_wdata   <= d;
		{s_axi_awvalid, s_axi_wvalid, s_axi_bready} <= 3'h7;
		for (k = 0; k < 50; k++) begin
			@(negedge aclk);
			if (!(s_axi_awvalid | s_axi_wvalid))
				break;
			aw = s_axi_awvalid & s_axi_awready;
			w = s_axi_wvalid & s_axi_wready;
			@(posedge aclk);
			if (aw)
				s_axi_awvalid <= 1'b0;
			if (w)
				s_axi_wvalid <= 1'b0;
		end
		if (k >= 50) `TMO
		`WAITHI(s_axi_bvalid)
		s_axi_bready <= 1'b0;
	endtask

	always @(negedge aclk) begin
		if (erase_wr === 1'b1)
			ecnt <= ecnt + ((erase_addr === ecnt[11:0]) ? 1 : 1000);
		if (notes.size() > 0) begin
			nt = notes[0];
			case (nt.kind)
				0: act = {20'h0, settings};
				1: act = {26'h0, prog_rdata};
				2: act = {33'h0, halt_reset_req};
				3: act = {s_axi_rresp, s_axi_rdata};
				4: act = {32'h0, s_axi_rvalid ? s_axi_rresp : s_axi_bresp};
				default: act = 34'(ecnt);
			endcase
			if ((nt.kind < 3 && look) || (nt.kind == 3 && s_axi_rvalid && s_axi_rready)
				|| (nt.kind == 4 && ((s_axi_bvalid && s_axi_bready) || (s_axi_rvalid && s_axi_rready)))
				|| (nt.kind == 5 && erase_wr === 1'b0 && ecnt != 0)) begin
				void'(notes.pop_front());
				`CHK(kn[nt.kind], nt.exp, act)
				if (nt.kind == 5)
					ecnt <= 0;
			end
		end
	end

	initial begin
		{seed, errors, n_compared, ecnt} = {32'd32, 96'h0};
		{look, aresetn, halt_entry, watchdog_active} = 4'h0;
		{s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready} = 5'h0;
		{s_axi_awaddr, s_axi_araddr, s_axi_wdata} = 56'h0;
		s_axi_wstrb = 4'hF;
		do_reset();
		note(0, {20'h0, exp_set(8'hFF, 8'hFF)});
		note(1, 34'h0);
		axi_rd(12'hFFC, 4, {32'h0, obcd_pkg::RESP_SLVERR});
		$display("test erased defaults done");
		i_tool.set_mode(1'b1);
		note(5, 34'd16);
		i_tool.write_byte(1'b0, 8'hFE, 1 + ($random(seed) & 3));
		drain();
		prev = exp_set(8'hFE, 8'hFF);
		note(0, {20'h0, prev});
		axi_rd(obcd_pkg::ADDR_STATUS, 3, {obcd_pkg::RESP_OKAY, 32'h5});
		axi_wr(obcd_pkg::ADDR_CTRL, 32'h1, obcd_pkg::RESP_OKAY);
		axi_rd(obcd_pkg::ADDR_STATUS, 3, {obcd_pkg::RESP_OKAY, 32'h1});
		axi_wr(12'hFFC, 32'h0, obcd_pkg::RESP_SLVERR);
		do_reset();
		note(0, {20'h0, prev});
		axi_rd(obcd_pkg::ADDR_DEC, 3, {obcd_pkg::RESP_OKAY, 18'h0, prev});
		$display("test erase done");
		for (i = 0; i < 8; i++) begin
			b0 = {6'h3F, i[0], 1'b1};
			b1 = 8'($random(seed));
			b1[6:2] = {i[2:0], i[1:0]};
			i_tool.set_mode(1'b1);
			i_tool.write_byte(1'b1, b1, 1 + ($random(seed) & 3));
			i_tool.write_byte(1'b0, b0, 1);
			note(1, {26'h0, b0});
			note(0, {20'h0, prev});
			i_tool.set_mode(1'b0);
			i_tool.write_byte(1'b1, ~b1, 1);
			note(1, 34'h0);
			do_reset();
			prev = exp_set(b0, b1);
			note(0, {20'h0, prev});
			h = 2'($random(seed));
			{halt_entry, watchdog_active} <= h;
			note(2, {33'h0, &h & b1[1]});
		end
		$display("test decode loop done");
		drain();
		print_verdict();
	end
endmodule // tb
`default_nettype wire
